// ==== src/contactor_brake_supervisor.sv ====
// Contactor and brake sequencing with timed fault supervision.
// Assumes field inputs synchronous to clk and a one-cycle register port.
`timescale 1ns/1ps
`default_nettype none
module contactor_brake_supervisor
	import supervisor_pkg::*;
#(
	parameter int unsigned TICK_LEN  = supervisor_pkg::TICK_CYCLES,  // Cycles per 0.01 s
	parameter int unsigned HOUR_LEN  = supervisor_pkg::HOUR_TICKS    // Ticks per hour
) (
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        ce,
	input  wire supervisor_pkg::reg_req_s    req,
	output logic [supervisor_pkg::DW-1:0]    rdata,
	input  wire supervisor_pkg::field_in_s   field,
	output logic                             contactor_close,
	output logic                             power_enable,
	output logic                             zero_speed_cmd,
	output logic                             holding_brake_out,
	output var supervisor_pkg::faults_s      faults,
	output logic                             irq
);
	import supervisor_pkg::*;

	// Clamp a written value into its legal range
	function automatic logic [TW-1:0] clamp(input logic [DW-1:0] v,
		input logic [TW-1:0] lo, input logic [TW-1:0] hi);
		logic [TW-1:0] r;
		r = (v > DW'(hi)) ? hi : v[TW-1:0];
		clamp = (r < lo) ? lo : r;
	endfunction : clamp

	// Number of set bits in the history
	function automatic logic [CNT_W-1:0] ones(input logic [SLOTS-1:0] v);
		logic [CNT_W-1:0] n;
		n = '0;
		for (int i = 0; i < SLOTS; i++) begin
			n = n + CNT_W'(v[i]);
		end
		ones = n;
	endfunction : ones

	// Configuration registers
	logic [CTRL_W-1:0] ctrl_q;      // Mode switches
	logic [TW-1:0]     check_q;     // Contactor check time
	logic [TW-1:0]     dropout_q;   // Contactor dropout delay
	logic [TW-1:0]     rst_dly_q;   // Auto clear wait, seconds
	logic [TW-1:0]     quota_q;     // Auto clears per hour
	logic [TW-1:0]     superv_q;    // Brake supervision time
	logic [TW-1:0]     zero_thr_q;  // Zero speed threshold
	logic [TW-1:0]     off_dly_q;   // Holding output off delay
	logic [EV_W-1:0]   irq_st_q;    // Sticky event bits
	logic [EV_W-1:0]   irq_mask_q;  // Event enables
	logic [DW-1:0]     rdata_q;     // Read data register

	// Time base
	logic [31:0] pre_q;  // Prescaler count
	wire         tick;   // One 0.01 s pulse
	assign tick = (pre_q == 32'(TICK_LEN - 1));

	// Decoded write strobes
	wire wr_ctrl   = req.we && (req.addr == CTRL_OFS);
	wire wr_check  = req.we && (req.addr == CHECK_OFS);
	wire wr_drop   = req.we && (req.addr == DROPOUT_OFS);
	wire wr_rdly   = req.we && (req.addr == RST_DLY_OFS);
	wire wr_quota  = req.we && (req.addr == QUOTA_OFS);
	wire wr_superv = req.we && (req.addr == SUPERV_OFS);
	wire wr_zthr   = req.we && (req.addr == ZERO_THR_OFS);
	wire wr_offd   = req.we && (req.addr == OFF_DLY_OFS);
	wire wr_ist    = req.we && (req.addr == IRQ_ST_OFS);
	wire wr_imask  = req.we && (req.addr == IRQ_MASK_OFS);
	wire man_clear = req.we && (req.addr == CLEAR_OFS) && req.wdata[0];

	// Mode switches
	wire       confirm_en = ctrl_q[CONFIRM_EN_BIT];
	wire       brake_chk  = ctrl_q[BRAKE_CHK_BIT];
	wire       auto_en    = ctrl_q[AUTO_CLR_BIT];
	wire       rel_brake  = ctrl_q[REL_BRAKE_BIT];
	wire [1:0] lift_confirm_source = ctrl_q[CONFIRM_LSB +: 2];
	wire       speed_command_origin = ctrl_q[PRESET_SPD_BIT];

	// State registers
	logic    contactor_q;    // Contactor close command
	logic    power_q;        // Power output enabled
	logic    zero_spd_q;     // Zero speed forced
	logic    holding_q;      // Holding brake output
	faults_s faults_q;       // Latched faults

	// Timer results
	wire chk_exp;   // Contactor check elapsed
	wire on_exp;    // Start delay elapsed
	wire drop_exp;  // Dropout delay elapsed
	wire mis_exp;   // Brake mismatch elapsed
	wire zs_exp;    // Stop supervision elapsed
	wire off_exp;   // Holding off delay elapsed
	wire clr_exp;   // Auto clear wait elapsed

	wire at_zero = field.speed <= zero_thr_q;

	wire holding_en = ctrl_q[HOLD_ASSIGN_BIT] && speed_command_origin && rel_brake &&
		((lift_confirm_source == CONFIRM_INTERNAL) ||
		 (lift_confirm_source == CONFIRM_EXTERNAL));

	wire fault_any = faults_q.contactor || faults_q.mismatch;

	// Clear history and quota
	logic [SLOTS-1:0] busy_q;     // Slot holds a recent clear
	wire  [SLOTS-1:0] free_first; // Lowest free slot, one-hot
	wire  [CNT_W-1:0] used;       // Clears in the last hour
	wire              quota_full;
	assign free_first = ~busy_q & (busy_q + SLOTS'(1));
	assign used       = ones(busy_q);
	assign quota_full = {12'h000, used} >= quota_q;

	wire clr_run    = auto_en && fault_any && !quota_full;
	wire auto_clear = clr_run && clr_exp;
	wire [TW-1:0] clr_limit = TW'(rst_dly_q * TICKS_PER_S);

	// contactor feedback check
	// Timer rests while the fault is latched, so a clear re-arms it
	wire chk_run = confirm_en && !faults_q.contactor && (field.contactor_fb != contactor_q);
	// brake feedback check
	// Same re-arm behaviour as the contactor check
	wire mis_run = brake_chk && !faults_q.mismatch && (field.brake_fb != field.brake_cmd);
	wire drop_run = contactor_q && !field.reg_release && !field.run_cmd;
	// stop supervision starts at run removal
	wire zs_run = !field.run_cmd;

	// Timer instances: run condition and limit per timer
	localparam int unsigned NT = 7;
	wire [NT-1:0]    t_run;
	wire [NT-1:0]    t_exp;
	wire [TW-1:0]    t_lim [NT];
	assign t_run = {clr_run, at_zero, zs_run, mis_run, drop_run, contactor_q, chk_run};
	assign t_lim[0] = check_q;
	assign t_lim[1] = check_q;
	assign t_lim[2] = dropout_q;
	assign t_lim[3] = superv_q;
	assign t_lim[4] = superv_q;
	assign t_lim[5] = off_dly_q;
	assign t_lim[6] = clr_limit;
	assign {clr_exp, off_exp, zs_exp, mis_exp, drop_exp, on_exp, chk_exp} = t_exp;

	genvar g;
	generate
		for (g = 0; g < NT; g++) begin : g_timer
			interval_timer u_timer (
				.clk     (clk),
				.rst_b   (rst_b),
				.ce      (ce),
				.tick    (tick),
				.run     (t_run[g]),
				.limit   (t_lim[g]),
				.expired (t_exp[g])
			);
		end
	endgenerate

	generate
		for (g = 0; g < SLOTS; g++) begin : g_slot
			logic [AGE_W-1:0] age_q;  // Ticks since the clear
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					busy_q[g] <= 1'b0;
					age_q     <= '0;
				end else if (ce) begin
					if (auto_clear && free_first[g]) begin
						busy_q[g] <= 1'b1;
						age_q     <= '0;
					end else if (busy_q[g] && tick) begin
						age_q <= AGE_W'(age_q + AGE_W'(1));
						if (age_q == AGE_W'(HOUR_LEN - 1)) begin
							busy_q[g] <= 1'b0;
						end
					end
				end
			end
		end
	endgenerate

	// Next state of the faults; a new event beats a clear
	wire     clearing = man_clear || auto_clear;
	faults_s faults_d;
	assign faults_d.contactor = chk_exp || (faults_q.contactor && !clearing);
	assign faults_d.mismatch  = mis_exp || (faults_q.mismatch && !clearing);

	// power waits check time after close
	// No power in the cycle a contactor fault is raised
	wire power_d = contactor_q && on_exp && !fault_any && !chk_exp;
	wire contactor_d = (field.run_cmd && !fault_any) || (contactor_q && !drop_exp);
	wire zero_spd_d = rel_brake && !field.run_cmd && !zs_exp;
	wire holding_d = holding_en && !(at_zero && off_exp);

	// Interrupt events
	wire [EV_W-1:0] events;
	assign events[EV_CONTACTOR] = chk_exp && !faults_q.contactor;
	assign events[EV_MISMATCH]  = mis_exp && !faults_q.mismatch;
	assign events[EV_AUTOCLR]   = auto_clear;
	assign events[EV_QUOTA]     = auto_en && fault_any && quota_full && !irq_st_q[EV_QUOTA];

	// Read mux
	wire [DW-1:0] state_word = {22'h000000, used, holding_q, zero_spd_q, power_q,
		contactor_q, faults_q.mismatch, faults_q.contactor};
	wire [DW-1:0] rd_mux =
		(req.addr == CTRL_OFS)     ? {24'h000000, ctrl_q} :
		(req.addr == CHECK_OFS)    ? {16'h0000, check_q} :
		(req.addr == DROPOUT_OFS)  ? {16'h0000, dropout_q} :
		(req.addr == RST_DLY_OFS)  ? {16'h0000, rst_dly_q} :
		(req.addr == QUOTA_OFS)    ? {16'h0000, quota_q} :
		(req.addr == SUPERV_OFS)   ? {16'h0000, superv_q} :
		(req.addr == ZERO_THR_OFS) ? {16'h0000, zero_thr_q} :
		(req.addr == OFF_DLY_OFS)  ? {16'h0000, off_dly_q} :
		(req.addr == STATE_OFS)    ? state_word :
		(req.addr == IRQ_ST_OFS)   ? {28'h0000000, irq_st_q} :
		(req.addr == IRQ_MASK_OFS) ? {28'h0000000, irq_mask_q} : 32'h00000000;

	// Prescaler
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_q <= 32'h00000000;
		end else if (ce) begin
			pre_q <= tick ? 32'h00000000 : pre_q + 32'h00000001;
		end
	end

	// Configuration writes; time, threshold and quota values clamped to legal ranges, control and mask bits stored as written
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_q     <= '0;
			check_q    <= CHECK_RST;
			dropout_q  <= DROPOUT_RST;
			rst_dly_q  <= RST_DLY_RST;
			quota_q    <= QUOTA_RST;
			superv_q   <= SUPERV_RST;
			zero_thr_q <= ZERO_THR_RST;
			off_dly_q  <= OFF_DLY_RST;
			irq_mask_q <= '0;
		end else if (ce) begin
			if (wr_ctrl)   ctrl_q     <= req.wdata[CTRL_W-1:0];
			if (wr_check)  check_q    <= clamp(req.wdata, CHECK_MIN, CHECK_MAX);
			if (wr_drop)   dropout_q  <= clamp(req.wdata, ZERO_FLOOR, DROPOUT_MAX);
			if (wr_rdly)   rst_dly_q  <= clamp(req.wdata, ZERO_FLOOR, RST_DLY_MAX);
			if (wr_quota)  quota_q    <= clamp(req.wdata, ZERO_FLOOR, QUOTA_MAX);
			if (wr_superv) superv_q   <= clamp(req.wdata, ZERO_FLOOR, SUPERV_MAX);
			if (wr_zthr)   zero_thr_q <= clamp(req.wdata, ZERO_FLOOR, ZERO_THR_MAX);
			if (wr_offd)   off_dly_q  <= clamp(req.wdata, ZERO_FLOOR, OFF_DLY_MAX);
			if (wr_imask)  irq_mask_q <= req.wdata[EV_W-1:0];
		end
	end

	// Sticky events, write one to clear, set wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_st_q <= '0;
		end else if (ce) begin
			irq_st_q <= events | (irq_st_q & ~(wr_ist ? req.wdata[EV_W-1:0] : '0));
		end
	end

	// Sequencing state and read data
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			contactor_q <= 1'b0;
			power_q     <= 1'b0;
			zero_spd_q  <= 1'b0;
			holding_q   <= 1'b0;
			faults_q    <= '0;
			rdata_q     <= '0;
		end else if (ce) begin
			contactor_q <= contactor_d;
			power_q     <= power_d;
			zero_spd_q  <= zero_spd_d;
			holding_q   <= holding_d;
			faults_q    <= faults_d;
			rdata_q     <= req.re ? rd_mux : '0;
		end
	end

	// Outputs
	assign rdata             = rdata_q;
	assign contactor_close   = contactor_q;
	assign power_enable      = power_q;
	assign zero_speed_cmd    = zero_spd_q;
	assign holding_brake_out = holding_q;
	assign faults            = faults_q;
	assign irq               = |(irq_st_q & irq_mask_q);

	// Checks on the sequencing
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_run_withdrawn;
		ce && $fell(field.run_cmd);
	endsequence
	sequence s_drop_pending;
		ce && drop_run && !drop_exp;
	endsequence

	a_contact_fault_cause: assert property ($rose(faults_q.contactor) |-> $past(chk_exp))
		else $error("contactor fault without elapsed check");
	a_power_after_delay: assert property ($rose(power_q) |-> $past(on_exp) && contactor_q)
		else $error("power enabled before check time");
	a_dropout_hold: assert property (s_drop_pending |=> contactor_q)
		else $error("contactor dropped inside dropout delay");
	a_auto_clear_wait: assert property (auto_clear |-> clr_exp && auto_en)
		else $error("auto clear before wait");
	a_quota_bound: assert property (auto_clear |-> ({12'h000, used} < quota_q))
		else $error("auto clear over hourly quota");
	a_quota_latch: assert property (ce && quota_full && fault_any && !man_clear
		&& !wr_ctrl |=> fault_any)
		else $error("fault cleared with quota used up");
	a_mismatch_cause: assert property ($rose(faults_q.mismatch) |-> $past(mis_exp))
		else $error("mismatch fault without elapsed time");
	a_zero_after_stop: assert property (s_run_withdrawn ##0 (rel_brake && superv_q != '0
		&& !$past(zs_run)) |=> zero_spd_q)
		else $error("zero speed not forced after stop");
	a_holding_gate: assert property (holding_q |-> $past(holding_en))
		else $error("holding output without enabling conditions");
	a_holding_off: assert property (ce && holding_en && at_zero && off_exp |=> !holding_q)
		else $error("holding output kept past off delay");
	a_zero_level: assert property (ce && holding_en && !at_zero |=> holding_q)
		else $error("holding output dropped above zero threshold");

endmodule : contactor_brake_supervisor
`default_nettype wire

// ==== src/supervisor_pkg.sv ====
// Constants, register map and carrier types for the contactor/brake supervisor.
// Assumes a 100 MHz system clock and a plain one-cycle register port.
package supervisor_pkg;

	// Clock and time base
	localparam int unsigned CLK_PERIOD_NS  = 10;          // System clock period
	localparam int unsigned TICK_PERIOD_NS = 10_000_000;  // One 0.01 s time unit
	localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned TICKS_PER_S    = 1_000_000_000 / TICK_PERIOD_NS;
	localparam int unsigned HOUR_S         = 3600;        // Clearing window
	localparam int unsigned HOUR_TICKS     = HOUR_S * TICKS_PER_S;

	// Widths
	localparam int unsigned AW      = 8;   // Register address width
	localparam int unsigned DW      = 32;  // Register data width
	localparam int unsigned TW      = 16;  // Timer limit width
	localparam int unsigned AGE_W   = 19;  // Clear history age width
	localparam int unsigned SLOTS   = 10;  // Largest quota
	localparam int unsigned CNT_W   = 4;   // Slot count width

	// Register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFS      = 8'h00;
	localparam logic [7:0] CHECK_OFS     = 8'h04;
	localparam logic [7:0] DROPOUT_OFS   = 8'h08;
	localparam logic [7:0] RST_DLY_OFS   = 8'h0C;
	localparam logic [7:0] QUOTA_OFS     = 8'h10;
	localparam logic [7:0] SUPERV_OFS    = 8'h14;
	localparam logic [7:0] ZERO_THR_OFS  = 8'h18;
	localparam logic [7:0] OFF_DLY_OFS   = 8'h1C;
	localparam logic [7:0] STATE_OFS     = 8'h20;
	localparam logic [7:0] IRQ_ST_OFS    = 8'h24;
	localparam logic [7:0] IRQ_MASK_OFS  = 8'h28;
	localparam logic [7:0] CLEAR_OFS     = 8'h2C;

	// Control field positions
	localparam int unsigned CONFIRM_EN_BIT  = 0;
	localparam int unsigned BRAKE_CHK_BIT   = 1;
	localparam int unsigned AUTO_CLR_BIT    = 2;
	localparam int unsigned HOLD_ASSIGN_BIT = 3;
	localparam int unsigned PRESET_SPD_BIT  = 4;
	localparam int unsigned REL_BRAKE_BIT   = 5;
	localparam int unsigned CONFIRM_LSB     = 6;
	localparam int unsigned CTRL_W          = 8;

	// Lift confirmation sources
	localparam logic [1:0] CONFIRM_NONE     = 2'h0;
	localparam logic [1:0] CONFIRM_INTERNAL = 2'h1;
	localparam logic [1:0] CONFIRM_EXTERNAL = 2'h2;

	// Reset values and ranges, in 0.01 s, s, count or 0.01 %
	localparam logic [TW-1:0] CHECK_RST    = 16'h0032;  // 0.50 s
	localparam logic [TW-1:0] CHECK_MIN    = 16'h000A;  // 0.10 s
	localparam logic [TW-1:0] CHECK_MAX    = 16'h01F4;  // 5.00 s
	localparam logic [TW-1:0] DROPOUT_RST  = 16'h0000;
	localparam logic [TW-1:0] DROPOUT_MAX  = 16'h01F4;  // 5.00 s
	localparam logic [TW-1:0] RST_DLY_RST  = 16'h0005;  // 5 s
	localparam logic [TW-1:0] RST_DLY_MAX  = 16'h0078;  // 120 s
	localparam logic [TW-1:0] QUOTA_RST    = 16'h0003;
	localparam logic [TW-1:0] QUOTA_MAX    = 16'h000A;
	localparam logic [TW-1:0] SUPERV_RST   = 16'h0064;  // 1.00 s
	localparam logic [TW-1:0] SUPERV_MAX   = 16'h01F4;  // 5.00 s
	localparam logic [TW-1:0] ZERO_THR_RST = 16'h0000;  // 0.00 %
	localparam logic [TW-1:0] ZERO_THR_MAX = 16'h00C8;  // 2.00 %
	localparam logic [TW-1:0] OFF_DLY_RST  = 16'h0000;  // 0.00 s
	localparam logic [TW-1:0] OFF_DLY_MAX  = 16'h03E7;  // 9.99 s
	localparam logic [TW-1:0] ZERO_FLOOR   = 16'h0000;

	// Interrupt event bits
	localparam int unsigned EV_CONTACTOR = 0;
	localparam int unsigned EV_MISMATCH  = 1;
	localparam int unsigned EV_AUTOCLR   = 2;
	localparam int unsigned EV_QUOTA     = 3;
	localparam int unsigned EV_W         = 4;

	// Register port request
	typedef struct packed {
		logic [AW-1:0] addr;   // Byte address
		logic [DW-1:0] wdata;  // Write data
		logic          we;     // Write strobe
		logic          re;     // Read strobe
	} reg_req_s;

	// Field inputs from the drive and contacts
	typedef struct packed {
		logic          run_cmd;       // Run command present
		logic          reg_release;   // Speed regulator release
		logic          contactor_fb;  // Auxiliary contact feedback
		logic          brake_cmd;     // Brake lift command
		logic          brake_fb;      // Brake feedback contact
		logic [TW-1:0] speed;         // Speed, 0.01 % of contract
	} field_in_s;

	// Latched faults
	typedef struct packed {
		logic mismatch;   // Release mismatch fault
		logic contactor;  // Contactor fault
	} faults_s;

endpackage : supervisor_pkg

// ==== src/interval_timer.sv ====
// Tick-driven interval timer used for every supervised delay.
// Assumes a one-cycle tick pulse from the shared time base.
`timescale 1ns/1ps
`default_nettype none
module interval_timer
	import supervisor_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        rst_b,
	input  wire logic                        ce,
	input  wire logic                        tick,
	input  wire logic                        run,
	input  wire logic [supervisor_pkg::TW-1:0] limit,
	output logic                             expired
);

	logic [TW-1:0] count_q;  // Elapsed ticks while running
	logic [TW-1:0] count_d;  // Next elapsed count
	wire           below;    // Limit not yet reached

	assign below   = count_q < limit;
	// Idle clears, running counts up to the limit
	assign count_d = !run ? ZERO_FLOOR :
		((tick && below) ? TW'(count_q + TW'(1)) : count_q);
	// Zero limit expires at once
	assign expired = run && !below;

	// Count register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= ZERO_FLOOR;
		end else if (ce) begin
			count_q <= count_d;
		end
	end

endmodule : interval_timer
`default_nettype wire

// ==== tb/contact_model.sv ====
// Behavioural motor contactor and brake with feedback contacts.
// Assumes the close command from the supervisor and the brake command from the bench; each contact follows after lag cycles.
`timescale 1ns/1ps
`default_nettype none
module contact_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       close_cmd,
	input  wire logic       brake_cmd,
	input  wire logic [7:0] lag,
	input  wire logic       stuck_c,
	input  wire logic       stuck_b,
	output logic            contactor_fb,
	output logic            brake_fb
);
	logic [7:0] c_cnt_q;  // Contactor travel count
	logic [7:0] b_cnt_q;  // Brake travel count
	// Contacts move after lag cycles; a stuck contact keeps its place
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			c_cnt_q      <= 8'h00;
			b_cnt_q      <= 8'h00;
			contactor_fb <= 1'b0;
			brake_fb     <= 1'b0;
		end else begin
			c_cnt_q <= (contactor_fb != close_cmd) ? c_cnt_q + 8'h01 : 8'h00;
			b_cnt_q <= (brake_fb != brake_cmd) ? b_cnt_q + 8'h01 : 8'h00;
			if (!stuck_c && c_cnt_q >= lag) contactor_fb <= close_cmd;
			if (!stuck_b && b_cnt_q >= lag) brake_fb <= brake_cmd;
		end
	end
endmodule : contact_model
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the contactor and brake supervisor.
// Assumes the contact model and short tick and hour parameters.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import supervisor_pkg::*;
	localparam int unsigned TK = 4;     // Cycles per tick
	localparam int unsigned HR = 2000;  // Ticks per hour
	logic          clk;          // System clock
	logic          rst_b;        // Reset, active low
	logic          ce_in;        // Clock enable
	reg_req_s      req;          // Register request
	logic [DW-1:0] rdata;        // Read data
	logic          run_cmd;      // Run command
	logic          reg_release;  // Regulator release
	logic          brake_cmd;    // Brake lift command
	logic [TW-1:0] speed;        // Speed level
	logic [7:0]    lag;          // Contact travel
	logic          stuck_c;      // Contactor frozen
	logic          stuck_b;      // Brake frozen
	wire logic     c_fb;         // Contactor feedback
	wire logic     b_fb;         // Brake feedback
	field_in_s     fld;          // Field inputs
	logic          close;        // Contactor command
	logic          pe;           // Power enable
	logic          zs;           // Zero speed command
	logic          hold;         // Holding brake output
	logic          irq;          // Interrupt
	faults_s       flt;          // Latched faults
	int            miscompares = 0;
	int            checks_done = 0;
	int            cycles_run  = 0;
	assign fld = {run_cmd, reg_release, c_fb, brake_cmd, b_fb, speed};
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	contactor_brake_supervisor #(.TICK_LEN(TK), .HOUR_LEN(HR)) u_dut (
		.clk(clk), .rst_b(rst_b), .ce(ce_in), .req(req), .rdata(rdata), .field(fld),
		.contactor_close(close), .power_enable(pe), .zero_speed_cmd(zs),
		.holding_brake_out(hold), .faults(flt), .irq(irq));
	contact_model u_contacts (
		.clk(clk), .rst_b(rst_b), .close_cmd(close), .brake_cmd(brake_cmd), .lag(lag),
		.stuck_c(stuck_c), .stuck_b(stuck_b), .contactor_fb(c_fb), .brake_fb(b_fb));
	task automatic finish_test;
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// Cut a hung run short
	always @(posedge clk) begin
		cycles_run <= cycles_run + 1;
		if (cycles_run == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk
	task automatic chb(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask : chb
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req.addr  <= a;
		req.wdata <= d;
		req.we    <= 1'b1;
		@(posedge clk);
		req.we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		req.addr <= a;
		req.re   <= 1'b1;
		@(posedge clk);
		req.re <= 1'b0;
		#1;
		chk("rdata", e, rdata);
	endtask : rd
	// Four cycles of reset with all field inputs idle
	task automatic reset_dut;
		@(posedge clk);
		rst_b <= 1'b0;
		req <= '0;
		{run_cmd, reg_release, brake_cmd, stuck_c, stuck_b} <= 5'h00;
		speed <= 16'h0000;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
	endtask : reset_dut
	// Reset values, clamping and an unmapped place
	task automatic t_regs;
		reset_dut();
		rd(CHECK_OFS, 32'h32);
		rd(RST_DLY_OFS, 32'h5);
		rd(QUOTA_OFS, 32'h3);
		rd(SUPERV_OFS, 32'h64);
		rd(ZERO_THR_OFS, 32'h0);
		rd(8'h3C, 32'h0);
		wr(CHECK_OFS, 32'h2);
		rd(CHECK_OFS, 32'hA);
		wr(OFF_DLY_OFS, 32'hFFFF);
		rd(OFF_DLY_OFS, 32'h3E7);
	endtask : t_regs
	// Close, delayed power, dropout delay
	task automatic t_seq;
		reset_dut();
		wr(CTRL_OFS, 32'h1);
		wr(CHECK_OFS, 32'hA);
		wr(DROPOUT_OFS, 32'hA);
		@(posedge clk);
		run_cmd     <= 1'b1;
		reg_release <= 1'b1;
		cyc(3);
		chb("close", 1'b1, close);
		cyc(30);
		chb("power", 1'b0, pe);
		cyc(15);
		chb("power", 1'b1, pe);
		@(posedge clk);
		run_cmd     <= 1'b0;
		reg_release <= 1'b0;
		cyc(30);
		chb("close", 1'b1, close);
		cyc(15);
		chb("close", 1'b0, close);
		chb("power", 1'b0, pe);
		chb("cfault", 1'b0, flt.contactor);
	endtask : t_seq
	// Contactor never confirms; interrupt and manual clear
	task automatic t_cfault;
		reset_dut();
		wr(CTRL_OFS, 32'h1);
		wr(CHECK_OFS, 32'hA);
		wr(IRQ_MASK_OFS, 32'h1);
		@(posedge clk);
		stuck_c <= 1'b1;
		run_cmd <= 1'b1;
		cyc(30);
		chb("cfault", 1'b0, flt.contactor);
		cyc(20);
		chb("cfault", 1'b1, flt.contactor);
		chb("irq", 1'b1, irq);
		chb("power", 1'b0, pe);
		wr(IRQ_ST_OFS, 32'h1);
		cyc(1);
		chb("irq", 1'b0, irq);
		wr(CLEAR_OFS, 32'h1);
		cyc(2);
		chb("cfault", 1'b0, flt.contactor);
	endtask : t_cfault
	// Automatic clear after wait, then quota of one exhausted
	task automatic t_autoclr;
		reset_dut();
		wr(CTRL_OFS, 32'h5);
		wr(CHECK_OFS, 32'hA);
		wr(RST_DLY_OFS, 32'h1);
		wr(QUOTA_OFS, 32'h1);
		wr(IRQ_MASK_OFS, 32'h8);
		@(posedge clk);
		stuck_c <= 1'b1;
		run_cmd <= 1'b1;
		cyc(50);
		chb("cfault", 1'b1, flt.contactor);
		cyc(380);
		chb("cfault", 1'b1, flt.contactor);
		cyc(25);
		chb("cfault", 1'b0, flt.contactor);
		cyc(50);
		chb("cfault", 1'b1, flt.contactor);
		cyc(450);
		chb("cfault", 1'b1, flt.contactor);
		chb("irq", 1'b1, irq);
		rd(STATE_OFS, 32'h45);
		rd(IRQ_ST_OFS, 32'hD);
	endtask : t_autoclr
	// Brake feedback follows, then sticks high
	task automatic t_mismatch;
		reset_dut();
		wr(CTRL_OFS, 32'h2);
		wr(SUPERV_OFS, 32'hA);
		@(posedge clk);
		brake_cmd <= 1'b1;
		cyc(60);
		chb("mfault", 1'b0, flt.mismatch);
		@(posedge clk);
		stuck_b   <= 1'b1;
		brake_cmd <= 1'b0;
		cyc(30);
		chb("mfault", 1'b0, flt.mismatch);
		cyc(20);
		chb("mfault", 1'b1, flt.mismatch);
		rd(IRQ_ST_OFS, 32'h2);
	endtask : t_mismatch
	// Zero speed held after run removal
	task automatic t_zero;
		reset_dut();
		wr(CTRL_OFS, 32'h20);
		wr(SUPERV_OFS, 32'hA);
		@(posedge clk);
		run_cmd <= 1'b1;
		cyc(5);
		chb("zero", 1'b0, zs);
		@(posedge clk);
		run_cmd <= 1'b0;
		cyc(30);
		chb("zero", 1'b1, zs);
		// Clock enable low freezes the supervision timer
		@(posedge clk);
		ce_in <= 1'b0;
		cyc(40);
		chb("zero", 1'b1, zs);
		@(posedge clk);
		ce_in <= 1'b1;
		cyc(20);
		chb("zero", 1'b0, zs);
	endtask : t_zero
	// Holding output enables, threshold and off delay
	task automatic t_hold;
		logic [7:0] cfg [6] = '{8'h78, 8'hB8, 8'h70, 8'h68, 8'h58, 8'h38};
		reset_dut();
		wr(ZERO_THR_OFS, 32'h64);
		wr(OFF_DLY_OFS, 32'hA);
		@(posedge clk);
		run_cmd <= 1'b1;
		speed   <= 16'h01F4;
		for (int i = 0; i < 6; i++) begin
			wr(CTRL_OFS, {24'h0, cfg[i]});
			cyc(3);
			chb("hold", i < 2, hold);
		end
		wr(CTRL_OFS, 32'h78);
		@(posedge clk);
		speed <= 16'h0064;
		cyc(30);
		chb("hold", 1'b1, hold);
		cyc(20);
		chb("hold", 1'b0, hold);
		@(posedge clk);
		speed <= 16'h0065;
		cyc(3);
		chb("hold", 1'b1, hold);
	endtask : t_hold
	// Main sequence
	initial begin
		rst_b = 1'b0;
		req = '0;
		{run_cmd, reg_release, brake_cmd, stuck_c, stuck_b} = 5'h00;
		speed = 16'h0000;
		lag = 8'h05;
		ce_in = 1'b1;
		t_regs();
		t_seq();
		t_cfault();
		t_autoclr();
		t_mismatch();
		t_zero();
		t_hold();
		finish_test();
	end
endmodule : testbench
`default_nettype wire
